// *** verilog/sfspi_pkg.sv ***
// Purpose: Shared constants and types of the serial flash slave.
// Assumes: Byte-wide array, three address bytes, MSB first.
// Notes:   Instruction codes and status layout are local choices.
package sfspi_pkg;
  localparam int ADDR_W    = 19;        // 524,288 bytes
  localparam int PAGE_W    = 8;         // 256 bytes per page
  localparam int SECT_W    = 3;         // 8 sectors
  localparam int PAGES     = 256;
  localparam int CNT_W     = 10;        // saturating byte count
  localparam logic [9:0] HDR_BYTES = 10'h004;
  localparam logic [9:0] STWR_BYTES = 10'h002;
  localparam logic [7:0] ERASED  = 8'hff;
  localparam logic [2:0] BP_RESET = 3'h0;
  localparam logic [7:0] SIG_DEFAULT = 8'h5a;  // Arbitrary value

  localparam logic [7:0] OP_WR_UNLOCK = 8'h01;
  localparam logic [7:0] OP_WR_LOCK   = 8'h02;
  localparam logic [7:0] OP_STATUS_WR = 8'h03;
  localparam logic [7:0] OP_STATUS_RD = 8'h04;
  localparam logic [7:0] OP_PAGE_WR   = 8'h05;
  localparam logic [7:0] OP_SECT_CLR  = 8'h07;
  localparam logic [7:0] OP_CHIP_CLR  = 8'h08;
  localparam logic [7:0] OP_SLEEP     = 8'h09;
  localparam logic [7:0] OP_WAKE      = 8'h0a;

  localparam int SR_BUSY = 0;
  localparam int SR_WEL  = 1;
  localparam int SR_BP   = 2;            // bits 4:2
  localparam int SR_LOCK = 7;

  localparam int SYS_CLK_NS = 8;
  localparam int STWR_NS    = 1000;      // internal status-write cycle
  localparam int STWR_CYC   = (STWR_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_ERASE, ST_STWR} sfspi_state_t;
endpackage

// *** verilog/sfspi_link_if.sv ***
// Purpose: Carrier between the serial shifter and the command logic.
// Assumes: All signals live in the serial clock domain.
// Notes:   byte_done and rx_byte are valid at the capturing rising edge.
`timescale 1ns/1ps
interface sfspi_link_if;
  logic       byte_done;
  logic [7:0] rx_byte;
  logic [2:0] bit_cnt;
  logic       first_edge;
  logic [7:0] tx_byte;
  logic       tx_en;
  modport shifter (output byte_done, rx_byte, bit_cnt, first_edge, input tx_byte, tx_en);
  modport decoder (input byte_done, rx_byte, bit_cnt, first_edge, output tx_byte, tx_en);
endinterface

// *** verilog/sfspi_shifter.sv ***
// Purpose: Serial shift in/out with pause handling, on the serial clock.
// Assumes: Master in clock mode 0 or 3; select high clears the frame.
// Notes:   Pause pin is read raw; its meaning is tied to the clock level.
`timescale 1ns/1ps
module sfspi_shifter (
  input  wire logic    spi_clk,
  input  wire logic    cs_n,
  input  wire logic    hold_n,
  input  wire logic    mosi,
  output logic         miso_o,
  output logic         miso_oe,
  sfspi_link_if.shifter lnk
);
  logic [6:0] rx_sr_q;
  logic [2:0] bit_cnt_q;
  logic       started_q;
  logic [7:0] tx_sr_q;
  logic       paused_q;
  logic       pause_w;

  //////////////////////////////////////////////////////////////////////////////
  // Capture on rising edges; a low pause pin freezes the count
  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      rx_sr_q   <= 7'h00;
      bit_cnt_q <= 3'h0;
      started_q <= 1'b0;
      paused_q  <= 1'b0;
    end else begin
      // Rising edge closes the low phase, so it keeps the pause level seen then
      paused_q <= !hold_n;
      if (hold_n) begin
        rx_sr_q   <= {rx_sr_q[5:0], mosi};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        started_q <= 1'b1;
      end
    end
  end

  assign lnk.byte_done  = hold_n && (bit_cnt_q == 3'h7);
  assign lnk.rx_byte    = {rx_sr_q, mosi};
  assign lnk.bit_cnt    = bit_cnt_q;
  // A stray edge while deselected, as at a mode change, starts no frame
  assign lnk.first_edge = !cs_n && hold_n && !started_q;

  //////////////////////////////////////////////////////////////////////////////
  // Output changes only after falling edges, MSB first
  always_ff @(negedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      tx_sr_q <= 8'h00;
    end else begin
      if (hold_n) begin
        if (bit_cnt_q == 3'h0) tx_sr_q <= lnk.tx_byte;
        else tx_sr_q <= {tx_sr_q[6:0], 1'b0};
      end
    end
  end

  // Clock low: pause follows the pin; clock high: level held from the rising edge
  assign pause_w = spi_clk ? paused_q : !hold_n;
  assign miso_o  = tx_sr_q[7];
  assign miso_oe = lnk.tx_en && !cs_n && !pause_w;

  //////////////////////////////////////////////////////////////////////////////
  sequence s_clean_byte;
    hold_n [*8];
  endsequence
  property p_msb_first;
    @(posedge spi_clk) disable iff (cs_n)
      s_clean_byte ##0 lnk.byte_done |-> lnk.rx_byte[7] == $past(mosi, 7);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not in MSB");
  property p_pause_freeze;
    @(posedge spi_clk) disable iff (cs_n) !hold_n |=> bit_cnt_q == $past(bit_cnt_q);
  endproperty
  a_pause_freeze: assert property (p_pause_freeze) else $error("count moved in pause");
  property p_pause_quiet;
    @(posedge spi_clk) disable iff (cs_n) !hold_n |-> !miso_oe;
  endproperty
  a_pause_quiet: assert property (p_pause_quiet) else $error("output driven in pause");
endmodule

// *** verilog/sfspi_flash.sv ***
// Purpose: Serial flash slave: command capture, array program and erase.
// Assumes: sys_clk 125 MHz; serial clock stands still between frames.
// Notes:   Array is flip-flops; contents are undefined until erased.
// Behaviour
// - Output bits change only after falling serial clock edges.
// - Input bits are captured on rising serial clock edges.
// - Select high: deselected, output off; standby unless busy or in deep power-down.
// - No instruction accepted until a select falling edge after reset.
// - Pause pin low suspends the transfer, which resumes where it stopped.
// - While paused the output is off and clock and data are ignored.
// - Pause only applies while selected.
// - Works in clock mode 0 and mode 3 alike.
// - A page write takes up to 256 bytes, wrapping inside one page.
// - Programming only clears bits; erasing sets bytes to ff.
// - Array: 8 sectors of 256 pages of 256 bytes.
// - Busy flag stays set through program, erase and status write.
// - Raising select during a cycle does not stop it.
// - Sleep command enters deep power-down until the wake command.
// - In deep power-down every command but wake is ignored.
// - Write-protect pin freezes the protect-size bits when locked.
// - Sector clear wipes one sector; chip clear wipes the array.
// - Pause starts and ends only while the serial clock is low.
// - Modifying commands need a whole number of bytes in the frame.
// - All bytes travel most significant bit first.
// - Unlock latch clears at reset and when modifying commands complete.
`timescale 1ns/1ps
module sfspi_flash #(
  parameter int         ADDR_W = sfspi_pkg::ADDR_W,
  parameter logic [7:0] SIG    = sfspi_pkg::SIG_DEFAULT   // Arbitrary value
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              spi_clk,
  input  wire logic              cs_n,
  input  wire logic              mosi,
  input  wire logic              hold_n,
  input  wire logic              wp_n,
  output logic                   miso_o,
  output logic                   miso_oe,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic [7:0]             rd_data,
  output logic                   busy_flag,
  output logic                   write_unlock_latch,
  output logic [2:0]             protect_size_bits,
  output logic                   status_lock_bit,
  output logic                   deep_sleep,
  output logic                   standby
);
  import sfspi_pkg::*;

  localparam int ERASE_W = ADDR_W - SECT_W;

  generate
    if (ADDR_W < PAGE_W + SECT_W || ADDR_W > 24) begin : g_bad_addr
      $error("ADDR_W out of range");
    end
  endgenerate

  function automatic logic sect_prot(input logic [2:0] sect, input logic [2:0] bp);
    logic r;
    r = 1'b0;
    case (bp)
      3'h0: r = 1'b0;
      3'h1: r = (sect == 3'h7);
      3'h2: r = (sect >= 3'h6);
      3'h3: r = (sect >= 3'h4);
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  sfspi_link_if lnk ();

  sfspi_shifter u_shifter (
    .spi_clk (spi_clk),
    .cs_n    (cs_n),
    .hold_n  (hold_n),
    .mosi    (mosi),
    .miso_o  (miso_o),
    .miso_oe (miso_oe),
    .lnk     (lnk)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Link domain
  logic             link_rst;
  logic [CNT_W-1:0] byte_cnt_q;
  logic [CNT_W-1:0] byte_cnt_nx;
  logic             tx_en_q;
  logic             frame_tgl_q;
  logic [7:0]       stat_l1_q;
  logic [7:0]       stat_l2_q;
  logic [1:0]       sleep_l_q;
  logic [7:0]       op_q;
  logic [23:0]      addr_q;
  logic [7:0]       col_q;
  logic [7:0]       pbuf_q [PAGES];
  logic [PAGES-1:0] pvalid_q;
  logic             snap_align_q;
  logic [CNT_W-1:0] snap_bytes_q;

  assign link_rst = !resetn;
  assign byte_cnt_nx = (lnk.byte_done && byte_cnt_q != '1) ? byte_cnt_q + 10'h001 : byte_cnt_q;

  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      byte_cnt_q <= '0;
      tx_en_q    <= 1'b0;
    end else begin
      byte_cnt_q <= byte_cnt_nx;
      if (lnk.byte_done && byte_cnt_q == '0) begin
        tx_en_q <= (lnk.rx_byte == OP_STATUS_RD && !sleep_l_q[1])
                   || lnk.rx_byte == OP_WAKE;
      end
    end
  end

  // Frame token and status view; only this token tells a real frame
  always_ff @(posedge spi_clk or posedge link_rst) begin
    if (link_rst) begin
      frame_tgl_q <= 1'b0;
      stat_l1_q   <= 8'h00;
      stat_l2_q   <= 8'h00;
      sleep_l_q   <= 2'b00;
    end else begin
      if (lnk.first_edge) frame_tgl_q <= !frame_tgl_q;
      stat_l1_q <= {status_lock_bit, 2'b00, protect_size_bits, write_unlock_latch, busy_flag};
      stat_l2_q <= stat_l1_q;
      sleep_l_q <= {sleep_l_q[0], deep_sleep};
    end
  end

  assign lnk.tx_en   = tx_en_q;
  assign lnk.tx_byte = (op_q == OP_WAKE) ? SIG : stat_l2_q;

  // Frame contents persist after select rises so sys_clk can read them
  always_ff @(posedge spi_clk) begin
    if (!cs_n && hold_n) begin
      snap_align_q <= lnk.byte_done;
      snap_bytes_q <= byte_cnt_nx;
    end
    if (!cs_n && lnk.byte_done) begin
      if (byte_cnt_q == '0) begin
        op_q     <= lnk.rx_byte;
        pvalid_q <= '0;
      end else if (byte_cnt_q < HDR_BYTES) begin
        addr_q <= {addr_q[15:0], lnk.rx_byte};
        col_q  <= lnk.rx_byte;
      end else if (op_q == OP_PAGE_WR && !stat_l2_q[SR_BUSY]) begin
        pbuf_q[col_q]   <= lnk.rx_byte;
        pvalid_q[col_q] <= 1'b1;
        col_q           <= col_q + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // System domain crossings
  logic [2:0]   cs_s_q;
  logic [1:0]   tgl_s_q;
  logic [1:0]   wp_s_q;
  logic         armed_q;
  logic         seen_q;
  logic         cmd_ev;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cs_s_q  <= 3'h0;
      tgl_s_q <= 2'h0;
      wp_s_q  <= 2'h0;
    end else begin
      cs_s_q  <= {cs_s_q[1:0], cs_n};
      tgl_s_q <= {tgl_s_q[0], frame_tgl_q};
      wp_s_q  <= {wp_s_q[0], wp_n};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      armed_q <= 1'b0;
      seen_q  <= 1'b0;
    end else begin
      if (!cs_s_q[1] && cs_s_q[2]) armed_q <= 1'b1;
      if (cs_s_q[1] && !cs_s_q[2]) seen_q <= tgl_s_q[1];
    end
  end

  assign cmd_ev = cs_s_q[1] && !cs_s_q[2] && armed_q && (tgl_s_q[1] != seen_q);

  //////////////////////////////////////////////////////////////////////////////
  // Command decode
  sfspi_state_t      state_q;
  logic [ADDR_W-1:0] walk_q;
  logic [ADDR_W-1:0] last_q;
  logic [ADDR_W-1:0] base_q;
  logic [ADDR_W-1:0] cmd_addr;
  logic              wel_q;
  logic              sleep_q;
  logic [2:0]        bp_q;
  logic              lock_q;
  logic              go_c;
  logic              mod_ok;
  logic              prog_ok;
  logic              sect_ok;
  logic              chip_ok;
  logic              stwr_ok;
  logic              done_c;

  assign cmd_addr = addr_q[ADDR_W-1:0];
  assign go_c     = cmd_ev && !sleep_q && state_q == ST_IDLE && snap_bytes_q != '0;
  assign mod_ok   = go_c && snap_align_q && wel_q;
  assign prog_ok  = mod_ok && op_q == OP_PAGE_WR && snap_bytes_q > HDR_BYTES
                    && !sect_prot(cmd_addr[ADDR_W-1 -: SECT_W], bp_q);
  assign sect_ok  = mod_ok && op_q == OP_SECT_CLR && snap_bytes_q >= HDR_BYTES
                    && !sect_prot(cmd_addr[ADDR_W-1 -: SECT_W], bp_q);
  assign chip_ok  = mod_ok && op_q == OP_CHIP_CLR && bp_q == 3'h0;
  assign stwr_ok  = mod_ok && op_q == OP_STATUS_WR && snap_bytes_q == STWR_BYTES
                    && !(lock_q && !wp_s_q[1]);
  assign done_c   = state_q != ST_IDLE && walk_q == last_q;

  // Walk one byte or one wait step per cycle; select has no say here
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      walk_q  <= '0;
      last_q  <= '0;
      base_q  <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          walk_q <= '0;
          if (prog_ok) begin
            state_q <= ST_PROG;
            base_q  <= {cmd_addr[ADDR_W-1:PAGE_W], {PAGE_W{1'b0}}};
            last_q  <= ADDR_W'(PAGES - 1);
          end else if (sect_ok) begin
            state_q <= ST_ERASE;
            base_q  <= {cmd_addr[ADDR_W-1 -: SECT_W], {ERASE_W{1'b0}}};
            last_q  <= {{SECT_W{1'b0}}, {ERASE_W{1'b1}}};
          end else if (chip_ok) begin
            state_q <= ST_ERASE;
            base_q  <= '0;
            last_q  <= '1;
          end else if (stwr_ok) begin
            state_q <= ST_STWR;
            last_q  <= ADDR_W'(STWR_CYC - 1);
          end
        end
        default: begin
          walk_q <= walk_q + 1'b1;
          if (done_c) state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wel_q   <= 1'b0;
      sleep_q <= 1'b0;
      bp_q    <= BP_RESET;
      lock_q  <= 1'b0;
    end else begin
      if (cmd_ev && sleep_q && op_q == OP_WAKE && snap_bytes_q != '0) begin
        sleep_q <= 1'b0;
      end
      if (go_c && op_q == OP_SLEEP) sleep_q <= 1'b1;
      if (stwr_ok) begin
        bp_q   <= addr_q[SR_BP +: 3];
        lock_q <= addr_q[SR_LOCK];
      end
      if (go_c && op_q == OP_WR_UNLOCK) wel_q <= 1'b1;
      else if ((go_c && op_q == OP_WR_LOCK) || done_c) wel_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Array
  logic [7:0]        mem_q [2**ADDR_W];
  logic [ADDR_W-1:0] wa;
  logic [PAGE_W-1:0] col_w;

  assign wa    = base_q | walk_q;
  assign col_w = walk_q[PAGE_W-1:0];

  always_ff @(posedge sys_clk) begin
    if (state_q == ST_PROG && pvalid_q[col_w]) begin
      mem_q[wa] <= mem_q[wa] & pbuf_q[col_w];
    end else if (state_q == ST_ERASE) begin
      mem_q[wa] <= ERASED;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) rd_data <= 8'h00;
    else rd_data <= mem_q[rd_addr];
  end

  assign busy_flag          = state_q != ST_IDLE;
  assign write_unlock_latch = wel_q;
  assign protect_size_bits  = bp_q;
  assign status_lock_bit    = lock_q;
  assign deep_sleep         = sleep_q;
  assign standby            = cs_s_q[1] && !busy_flag && !sleep_q;

  //////////////////////////////////////////////////////////////////////////////
  property p_busy_needs_unlock;
    @(posedge sys_clk) disable iff (!resetn) $rose(busy_flag) |-> $past(wel_q);
  endproperty
  a_busy_needs_unlock: assert property (p_busy_needs_unlock) else $error("busy without unlock");
  property p_done_locks;
    @(posedge sys_clk) disable iff (!resetn) $fell(busy_flag) |-> !wel_q;
  endproperty
  a_done_locks: assert property (p_done_locks) else $error("latch kept after cycle");
  property p_sleep_holds;
    @(posedge sys_clk) disable iff (!resetn)
      sleep_q && cmd_ev && op_q != OP_WAKE |=> sleep_q && !busy_flag;
  endproperty
  a_sleep_holds: assert property (p_sleep_holds) else $error("command taken asleep");
  sequence s_sleep_cmd;
    go_c && op_q == OP_SLEEP;
  endsequence
  property p_sleep_enter;
    @(posedge sys_clk) disable iff (!resetn) s_sleep_cmd |=> sleep_q [*2];
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");
  property p_armed_first;
    @(posedge sys_clk) disable iff (!resetn) $rose(busy_flag) |-> armed_q;
  endproperty
  a_armed_first: assert property (p_armed_first) else $error("busy before select edge");
  property p_whole_bytes;
    @(posedge sys_clk) disable iff (!resetn)
      go_c && !snap_align_q |=> !busy_flag;
  endproperty
  a_whole_bytes: assert property (p_whole_bytes) else $error("partial byte accepted");
  property p_prog_runs;
    @(posedge sys_clk) disable iff (!resetn) $rose(state_q == ST_PROG) |-> busy_flag [*8];
  endproperty
  a_prog_runs: assert property (p_prog_runs) else $error("program cycle cut short");
  property p_deselect_quiet;
    @(posedge sys_clk) disable iff (!resetn) cs_n |-> !miso_oe;
  endproperty
  a_deselect_quiet: assert property (p_deselect_quiet) else $error("output on while off");
endmodule

// *** dv/sfspi_master.sv ***
// Purpose: Bus master model that drives the serial flash pins.
// Assumes: Clock mode 0 or 3; the clock stands still between frames.
// Notes:   A released data line is toggled so a stale level never passes.
`timescale 1ns/1ps
module sfspi_master (
  output logic      spi_clk,
  output logic      cs_n,
  output logic      mosi,
  output logic      hold_n,
  input  wire logic miso_o,
  input  wire logic miso_oe
);
  localparam int HP = 24;
  logic       cpol;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic [7:0] sh;
  int         hold_oe;

  initial begin
    cpol = 1'b0;
    spi_clk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    hold_n = 1'b1;
    hold_oe = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic set_mode(input logic m);
    cpol = m;
    spi_clk = m;
    #HP;
  endtask

  // Clock is low here, so the pause takes hold at once
  task automatic pause(input logic b);
    // Step off the falling edge so that edge still shifts the output
    #1;
    hold_n = 1'b0;
    repeat (3) begin
      #HP;
      spi_clk = ~spi_clk;
      mosi = ~mosi;
      #HP;
      if (miso_oe) hold_oe++;
      spi_clk = ~spi_clk;
    end
    #HP;
    hold_n = 1'b1;
    mosi = b;
  endtask

  task automatic frame(input int nbits, input int hold_at);
    rxq.delete();
    #3;
    cs_n = 1'b0;
    #HP;
    for (int i = 0; i < nbits; i++) begin
      spi_clk = 1'b0;
      mosi = txq[i / 8][7 - i % 8];
      if (i == hold_at) pause(mosi);
      #HP;
      // Sampled just ahead of the rising edge; pull-up when nobody drives it
      sh = {sh[6:0], miso_oe ? miso_o : 1'b1};
      if (i % 8 == 7) rxq.push_back(sh);
      spi_clk = 1'b1;
      #HP;
    end
    spi_clk = cpol;
    #HP;
    cs_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

// *** dv/sfspi_flash_tb.sv ***
// Purpose: Self-checking bench of the serial flash slave.
// Assumes: Sector clear is the longest wait, about 65536 cycles.
// Notes:   Array contents are only compared after an erase.
`timescale 1ns/1ps
module sfspi_flash_tb;
  import sfspi_pkg::*;
  logic        sys_clk, resetn, wp_n;
  logic        spi_clk, cs_n, mosi, hold_n, miso_o, miso_oe;
  logic        busy_flag, write_unlock_latch, status_lock_bit, deep_sleep, standby;
  logic [2:0]  protect_size_bits;
  logic [18:0] rd_addr;
  logic [7:0]  rd_data, act_v, e_w, s;
  logic [7:0]  exp_q[$];
  logic [7:0]  d[4];
  logic [31:0] rng;
  int          n_fail, n_tests;
  event        res_ev;
  wire  [7:0]  flg = {busy_flag, write_unlock_latch, status_lock_bit, deep_sleep, standby,
                      protect_size_bits};

  sfspi_flash sfspi_flash_inst (.sys_clk(sys_clk), .resetn(resetn), .spi_clk(spi_clk),
    .cs_n(cs_n), .mosi(mosi), .hold_n(hold_n), .wp_n(wp_n), .miso_o(miso_o),
    .miso_oe(miso_oe), .rd_addr(rd_addr), .rd_data(rd_data), .busy_flag(busy_flag),
    .write_unlock_latch(write_unlock_latch), .protect_size_bits(protect_size_bits),
    .status_lock_bit(status_lock_bit), .deep_sleep(deep_sleep), .standby(standby));
  sfspi_master sfspi_master_inst (.spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi),
    .hold_n(hold_n), .miso_o(miso_o), .miso_oe(miso_oe));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] e, input logic [7:0] a);
    exp_q.push_back(e);
    act_v = a;
    ->res_ev;
    #1;
  endtask

  always @(res_ev) begin
    e_w = exp_q.pop_front();
    n_tests++;
    if (e_w !== act_v) begin
      n_fail++;
      $display("unexpected at %0t: expected %h, got %h", $time, e_w, act_v);
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic send(input int nbits, input int hold_at);
    sfspi_master_inst.frame(nbits, hold_at);
    cyc(6);
  endtask

  task automatic op1(input logic [7:0] op);
    sfspi_master_inst.txq = '{op};
    send(8, -1);
  endtask

  // Bounded poll; running out counts as a mismatch
  task automatic wait_idle();
    for (int i = 0; i < 70000 && busy_flag !== 1'b0; i++) cyc(1);
    if (busy_flag !== 1'b0) begin
      n_fail++;
      report_and_stop();
    end
    cyc(2);
  endtask

  task automatic peek(input logic [18:0] a, input logic [7:0] e);
    rd_addr = a;
    cyc(2);
    chk(e, rd_data);
  endtask

  // Last byte is used: the status view lags at frame start
  task automatic rd3(input logic [7:0] op, input int hold_at, output logic [7:0] v);
    sfspi_master_inst.txq = '{op, 8'h00, 8'h00};
    send(24, hold_at);
    v = sfspi_master_inst.rxq[2];
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    wp_n = 1'b1;
    rd_addr = '0;
    rng = 32'hb81dabf9;
    n_fail = 0;
    n_tests = 0;
    cyc(19);
    chk(8'h00, {flg[7:4], 3'h0, miso_oe});
    cyc(1);
    resetn = 1'b1;
    cyc(6);
    chk(8'h08, flg);
    op1(OP_WR_UNLOCK);
    chk(8'h48, flg);
    sfspi_master_inst.txq = '{OP_SECT_CLR, 8'h00, 8'h00, 8'h00};
    send(31, -1);
    chk(8'h48, flg);
    send(32, -1);
    chk(8'hc0, flg);
    rd3(OP_STATUS_RD, 12, s);
    chk(8'h03, s);
    chk(8'h03, sfspi_master_inst.rxq[1]);
    chk(8'h00, {7'h0, miso_oe});
    wait_idle();
    chk(8'h08, flg);
    peek({3'h0, rnd(), rnd()}, ERASED);
    sfspi_master_inst.set_mode(1'b1);
    for (int i = 0; i < 4; i++) d[i] = rnd();
    op1(OP_WR_UNLOCK);
    sfspi_master_inst.txq = '{OP_PAGE_WR, 8'h00, 8'h12, 8'hfe, d[0], d[1], d[2]};
    send(56, 41);
    wait_idle();
    peek(19'h012fe, d[0]);
    peek(19'h012ff, d[1]);
    peek(19'h01200, d[2]);
    chk(8'h00, 8'(sfspi_master_inst.hold_oe));
    op1(OP_WR_UNLOCK);
    sfspi_master_inst.txq = '{OP_PAGE_WR, 8'h00, 8'h12, 8'hfe, d[3]};
    send(40, -1);
    wait_idle();
    peek(19'h012fe, d[0] & d[3]);
    op1(OP_SLEEP);
    chk(8'h10, flg);
    op1(OP_WR_UNLOCK);
    chk(8'h10, flg);
    rd3(OP_WAKE, -1, s);
    chk(SIG_DEFAULT, s);
    chk(8'h08, flg);
    op1(OP_WR_UNLOCK);
    sfspi_master_inst.txq = '{OP_STATUS_WR, 8'h8c};
    send(16, -1);
    wait_idle();
    chk(8'h2b, flg);
    wp_n = 1'b0;
    cyc(4);
    op1(OP_WR_UNLOCK);
    sfspi_master_inst.txq = '{OP_STATUS_WR, 8'h00};
    send(16, -1);
    chk(8'h6b, flg);
    sfspi_master_inst.txq = '{OP_CHIP_CLR};
    send(8, -1);
    chk(8'h6b, flg);
    sfspi_master_inst.txq = '{OP_SECT_CLR, 8'h07, 8'h00, 8'h00};
    send(32, -1);
    chk(8'h6b, flg);
    op1(OP_WR_LOCK);
    chk(8'h2b, flg);
    report_and_stop();
  end
endmodule
